// file: core/ilo_exec.sv
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none

`include "ilo_cfg.svh"

// Functional notes
// RULE1 - Extended mode, access operand at or below 5Fh becomes frame pointer plus offset.
// RULE2 - Offset remap only when access select bit is 0; else bank select register.
// RULE3 - Opcode 0010 01d0 adds work register to byte at frame pointer plus k.
// RULE4 - Add result goes to work register if d is 0, memory if 1.
// RULE5 - Add updates negative, overflow, carry, digit carry and zero flags.
// RULE6 - Opcode 1000 bbb0 sets bit b of indexed byte; flags unchanged.
module ilo_exec
    import ilo_pkg::*;
#(
    parameter int APB_AW = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    ilo_state_t               state;
    ilo_state_t               next_state;
    logic [1:0]               ctrl;
    logic [1:0]               next_ctrl;
    logic [7:0]               work;
    logic [7:0]               next_work;
    logic [`ILO_AW-1:0]       fp;
    logic [`ILO_AW-1:0]       next_fp;
    logic [3:0]               bank;
    logic [3:0]               next_bank;
    logic [4:0]               status;
    logic [4:0]               next_status;
    logic [15:0]              instr;
    logic [15:0]              next_instr;
    logic [`ILO_AW-1:0]       maddr;
    logic [`ILO_AW-1:0]       next_maddr;
    logic [`ILO_AW-1:0]       eaddr;
    logic [`ILO_AW-1:0]       next_eaddr;
    logic                     ack;
    logic                     next_ack;
    logic                     err;
    logic                     next_err;
    logic                     rd_mem;
    logic                     next_rd_mem;
    logic [31:0]              rdata_q;
    logic [31:0]              next_rdata_q;
    logic                     acc;
    logic                     first;
    logic                     wr_fire;
    logic                     mapped;
    logic [31:0]              rd_mux;
    logic [`ILO_AW-1:0]       launch_ea;
    logic                     launch_ok;
    logic [7:0]               opnd;
    logic                     is_add;
    logic                     is_bset;
    logic                     mem_we;
    logic                     mem_re;
    logic [`ILO_AW-1:0]       mem_addr;
    logic [7:0]               mem_wdata;
    logic [7:0]               mem_rdata;
    logic [7:0]               sum;
    logic [4:0]               flags;
    logic                     run_add;
    logic                     run_bset;
    logic [7:0]               bit_mask;

    // ****************************************************************
    // Leaf instances
    // ****************************************************************
    // Memory is not reset; its content is undefined until written
    ilo_mem #(
        .AW    (`ILO_AW),
        .DW    (8)
    ) u_mem (
        .pclk  (pclk),
        .we    (mem_we),
        .re    (mem_re),
        .addr  (mem_addr),
        .wdata (mem_wdata),
        .rdata (mem_rdata)
    );

    ilo_alu u_alu (
        .opa   (work),
        .opb   (mem_rdata),
        .sum   (sum),
        .flags (flags)
    );

    // ****************************************************************
    // APB decode
    // ****************************************************************
    assign acc     = psel && penable;
    // Taken only while idle, so a read after an instruction sees its results
    assign first   = acc && !ack && (state == ilo_st_idle);
    assign wr_fire = acc && ack && pwrite;
    assign pready  = ack;
    assign pslverr = ack && err;
    // Memory reads come straight from the memory's own read register
    assign prdata  = rd_mem ? {24'h000000, mem_rdata} : rdata_q;

    // Unmapped addresses answer with an error and read as zero
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h00000000;
        case (paddr)
            `ILO_OFS_CTRL:   rd_mux = {30'h00000000, ctrl};
            `ILO_OFS_WORK:   rd_mux = {24'h000000, work};
            `ILO_OFS_FP:     rd_mux = {20'h00000, fp};
            `ILO_OFS_BANK:   rd_mux = {28'h0000000, bank};
            `ILO_OFS_STATUS: rd_mux = {27'h0000000, status};
            `ILO_OFS_INSTR:  rd_mux = {16'h0000, instr};
            `ILO_OFS_MADDR:  rd_mux = {20'h00000, maddr};
            `ILO_OFS_MDATA:  rd_mux = 32'h00000000;
            `ILO_OFS_EADDR:  rd_mux = {20'h00000, eaddr};
            default:         mapped = 1'b0;
        endcase
    end

    always_comb begin
        next_ack     = first;
        next_err     = err;
        next_rd_mem  = 1'b0;
        next_rdata_q = rdata_q;
        if (first) begin
            next_err     = !mapped;
            next_rd_mem  = !pwrite && (paddr == `ILO_OFS_MDATA);
            next_rdata_q = rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack     <= 1'b0;
            err     <= 1'b0;
            rd_mem  <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack     <= next_ack;
            err     <= next_err;
            rd_mem  <= next_rd_mem;
            rdata_q <= next_rdata_q;
        end
    end

    // ****************************************************************
    // Operand address of an instruction being launched
    // ****************************************************************
    // Address is worked out at the launch write, so fetch can use it at once
    always_comb begin
        opnd    = pwdata[7:0];
        is_add  = (pwdata[15:10] == `ILO_OPC_ADD); // RULE3
        is_bset = (pwdata[15:12] == `ILO_OPC_BSET); // RULE6
        launch_ok = is_add || is_bset;
        if (pwdata[`ILO_OP_ACCESS]) begin
            launch_ea = {bank, opnd}; // RULE2
        end else if (ctrl[`ILO_CTRL_EXT] && (opnd <= `ILO_OFFSET_MAX)) begin
            launch_ea = fp + {4'h0, opnd}; // RULE1
        end else if (opnd <= `ILO_OFFSET_MAX) begin
            launch_ea = {4'h0, opnd};
        end else begin
            // Offsets above 5Fh of the access bank reach the special registers in bank F
            launch_ea = {`ILO_SFR_BANK, opnd};
        end
    end

    // ****************************************************************
    // Decode of the instruction held for execution
    // ****************************************************************
    assign run_add  = (instr[15:10] == `ILO_OPC_ADD); // RULE3
    assign run_bset = (instr[15:12] == `ILO_OPC_BSET); // RULE6
    assign bit_mask = 8'h01 << instr[11:9]; // RULE6

    // ****************************************************************
    // Memory port
    // ****************************************************************
    always_comb begin
        mem_re    = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = maddr;
        mem_wdata = pwdata[7:0];
        case (state)
            ilo_st_fetch: begin
                mem_addr = eaddr;
                mem_re   = 1'b1;
            end
            ilo_st_exec: begin
                // The operand read in fetch is modified here and written back unless an add targets the work register
                mem_addr = eaddr;
                if (run_add) begin
                    mem_we    = instr[`ILO_OP_DEST]; // RULE4
                    mem_wdata = sum;
                end else if (run_bset) begin
                    mem_we    = 1'b1;
                    mem_wdata = mem_rdata | bit_mask; // RULE6
                end
            end
            default: begin
                mem_re = first && !pwrite && (paddr == `ILO_OFS_MDATA);
                mem_we = wr_fire && (paddr == `ILO_OFS_MDATA);
            end
        endcase
    end

    // ****************************************************************
    // Sequencer and register file
    // ****************************************************************
    always_comb begin
        next_state  = state;
        next_ctrl   = ctrl;
        next_work   = work;
        next_fp     = fp;
        next_bank   = bank;
        next_status = status;
        next_instr  = instr;
        next_maddr  = maddr;
        next_eaddr  = eaddr;
        if (wr_fire) begin
            case (paddr)
                `ILO_OFS_CTRL: begin
                    next_ctrl[`ILO_CTRL_EXT] = pwdata[`ILO_CTRL_EXT];
                    // Write one clears; a set needs an instruction write, so both never meet
                    if (pwdata[`ILO_CTRL_ILL]) begin
                        next_ctrl[`ILO_CTRL_ILL] = 1'b0;
                    end
                end
                `ILO_OFS_WORK:   next_work   = pwdata[7:0];
                `ILO_OFS_FP:     next_fp     = pwdata[`ILO_AW-1:0];
                `ILO_OFS_BANK:   next_bank   = pwdata[3:0];
                `ILO_OFS_STATUS: next_status = pwdata[4:0];
                `ILO_OFS_MADDR:  next_maddr  = pwdata[`ILO_AW-1:0];
                `ILO_OFS_INSTR: begin
                    next_instr = pwdata[15:0];
                    next_eaddr = launch_ea;
                    if (launch_ok) begin
                        next_state = ilo_st_fetch;
                    end else begin
                        next_ctrl[`ILO_CTRL_ILL] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // Fetch and exec follow each other; the bus is held off meanwhile
        case (state)
            ilo_st_fetch: begin
                next_state = ilo_st_exec;
            end
            ilo_st_exec: begin
                next_state = ilo_st_idle;
                if (run_add) begin
                    next_status = flags; // RULE5
                    if (!instr[`ILO_OP_DEST]) begin
                        next_work = sum; // RULE4
                    end
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state  <= ilo_st_idle;
            ctrl   <= `ILO_RST_CTRL;
            work   <= `ILO_RST_BYTE;
            fp     <= `ILO_RST_ADDR;
            bank   <= `ILO_RST_BANK;
            status <= `ILO_RST_STATUS;
            instr  <= `ILO_RST_INSTR;
            maddr  <= `ILO_RST_ADDR;
            eaddr  <= `ILO_RST_ADDR;
        end else begin
            state  <= next_state;
            ctrl   <= next_ctrl;
            work   <= next_work;
            fp     <= next_fp;
            bank   <= next_bank;
            status <= next_status;
            instr  <= next_instr;
            maddr  <= next_maddr;
            eaddr  <= next_eaddr;
        end
    end

endmodule // ilo_exec

`default_nettype wire

// file: core/ilo_cfg.svh
`ifndef ILO_CFG_SVH
`define ILO_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ILO_OFS_CTRL    8'h00
`define ILO_OFS_WORK    8'h04
`define ILO_OFS_FP      8'h08
`define ILO_OFS_BANK    8'h0c
`define ILO_OFS_STATUS  8'h10
`define ILO_OFS_INSTR   8'h14
`define ILO_OFS_MADDR   8'h18
`define ILO_OFS_MDATA   8'h1c
`define ILO_OFS_EADDR   8'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define ILO_CTRL_EXT    0
`define ILO_CTRL_ILL    1
`define ILO_ST_C        0
`define ILO_ST_DC       1
`define ILO_ST_Z        2
`define ILO_ST_OV       3
`define ILO_ST_N        4
`define ILO_OP_ACCESS   8
`define ILO_OP_DEST     9

// ****************************************************************
// Widths, reset values and encodings
// ****************************************************************
`define ILO_AW          12
`define ILO_RST_CTRL    2'h0
`define ILO_RST_BYTE    8'h00
`define ILO_RST_ADDR    12'h000
`define ILO_RST_BANK    4'h0
`define ILO_RST_STATUS  5'h00
`define ILO_RST_INSTR   16'h0000
`define ILO_OFFSET_MAX  8'h5f
`define ILO_SFR_BANK    4'hf
`define ILO_OPC_ADD     6'h09
`define ILO_OPC_BSET    4'h8

`endif

// file: core/ilo_pkg.sv
package ilo_pkg;

    typedef enum logic [1:0] {
        ilo_st_idle,
        ilo_st_fetch,
        ilo_st_exec
    } ilo_state_t;

endpackage

// file: core/ilo_mem.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Data memory with registered read port
// ****************************************************************
module ilo_mem #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input  wire logic          pclk,
    input  wire logic          we,
    input  wire logic          re,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] store [0:(1<<AW)-1];

    always_ff @(posedge pclk) begin
        if (we) begin
            store[addr] <= wdata;
        end
        if (re) begin
            rdata <= store[addr];
        end
    end

endmodule // ilo_mem

`default_nettype wire

// file: core/ilo_alu.sv
`timescale 1ns/100ps
`default_nettype none

`include "ilo_cfg.svh"

// ****************************************************************
// Byte adder with status flags
// ****************************************************************
module ilo_alu (
    input  wire logic [7:0] opa,
    input  wire logic [7:0] opb,
    output logic      [7:0] sum,
    output logic      [4:0] flags
);

    logic [8:0] wide;
    logic [4:0] nib;

    always_comb begin
        wide = {1'b0, opa} + {1'b0, opb};
        nib  = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
        sum  = wide[7:0];
        flags = 5'h00;
        flags[`ILO_ST_C]  = wide[8];
        flags[`ILO_ST_DC] = nib[4];
        flags[`ILO_ST_Z]  = (wide[7:0] == 8'h00);
        flags[`ILO_ST_OV] = (opa[7] == opb[7]) && (wide[7] != opa[7]);
        flags[`ILO_ST_N]  = wide[7];
    end

endmodule // ilo_alu

`default_nettype wire

// file: bench/ilo_exec_sva.sv
`timescale 1ns/100ps
`default_nettype none

module ilo_exec_sva #(
    parameter int APB_AW = 8
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr
);
    // ****************************************************************
    // Shadow of software writes and expected effective address
    // ****************************************************************
    logic        wr, rd, is_add, is_bs, ins;
    logic        ext_q, w_ok, s_ok;
    logic [1:0]  ea_k;
    logic [3:0]  bk_q;
    logic [7:0]  w_q;
    logic [4:0]  s_q;
    logic [11:0] fp_q, ea_q;
    assign wr     = psel && penable && pready && pwrite;
    assign rd     = psel && penable && pready && !pwrite;
    assign ins    = wr && paddr == 8'h14;
    assign is_add = pwdata[15:10] == 6'h09;
    assign is_bs  = pwdata[15:12] == 4'h8;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ext_q, w_ok, s_ok, ea_k, bk_q, w_q, s_q, fp_q, ea_q} <= '0;
        end else begin
            if (wr && paddr == 8'h00) ext_q <= pwdata[0];
            if (wr && paddr == 8'h08) fp_q <= pwdata[11:0];
            if (wr && paddr == 8'h0c) bk_q <= pwdata[3:0];
            if (wr && paddr == 8'h04) w_q <= pwdata[7:0];
            if (wr && paddr == 8'h10) s_q <= pwdata[4:0];
            if (wr && paddr == 8'h04) w_ok <= 1'b1;
            if (wr && paddr == 8'h10) s_ok <= 1'b1;
            if (ins) begin
                ea_k <= pwdata[8] ? 2'h2 : (ext_q && pwdata[7:0] <= 8'h5f) ? 2'h1 : 2'h0;
                ea_q <= pwdata[8] ? {bk_q, pwdata[7:0]} : fp_q + {4'h0, pwdata[7:0]};
                w_ok <= w_ok && !(is_add && !pwdata[9]);
                s_ok <= s_ok && !is_add;
            end
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    a_ea_offset: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == 8'h20 && ea_k == 2'h1 |-> prdata[11:0] == ea_q) else $error("offset address wrong");
    a_ea_bank: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == 8'h20 && ea_k == 2'h2 |-> prdata[11:0] == ea_q) else $error("bank address wrong");
    a_add_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        ins && is_add ##2 (psel && !penable) |=> !pready ##1 pready) else $error("add not single cycle");
    a_bset_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        ins && is_bs ##2 (psel && !penable) |=> !pready ##1 pready) else $error("bit set not single cycle");
    a_work_kept: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == 8'h04 && w_ok |-> prdata[7:0] == w_q) else $error("work register changed");
    a_flags_kept: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == 8'h10 && s_ok |-> prdata[4:0] == s_q) else $error("flags changed by bit set");
endmodule // ilo_exec_sva

bind ilo_exec ilo_exec_sva #(.APB_AW(APB_AW)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata, rq;
    logic        pready, pslverr, re;
    int          n_errors, checks_done;

    ilo_exec #(.APB_AW(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    always #2.5 pclk = ~pclk;

    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("Error pready expected 1 seen %b", pready);
        end
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, exp, rq);
    endtask

    task automatic put(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, 8'h18, {20'h0, a});
        xfer(1'b1, 8'h1c, {24'h0, d});
    endtask

    task automatic add_case(input logic [7:0] k, w, m, input logic d, input logic [7:0] r, input logic [4:0] st);
        put(12'ha00 + {4'h0, k}, m);
        xfer(1'b1, 8'h04, {24'h0, w});
        xfer(1'b1, 8'h14, {16'h0, 6'h09, d, 1'b0, k});
        rd(8'h04, {24'h0, d ? w : r}, "work");
        rd(8'h1c, {24'h0, d ? r : m}, "memory");
        rd(8'h10, {27'h0, st}, "status");
        rd(8'h20, {20'h0, 12'ha00 + {4'h0, k}}, "eaddr");
    endtask

    task automatic close_out();
        $display("Checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b1, 8'h00, 32'h1);
        xfer(1'b1, 8'h08, 32'ha00);
        add_case(8'h2c, 8'h17, 8'h20, 1'b0, 8'h37, 5'h00);
        add_case(8'h2c, 8'h37, 8'h20, 1'b1, 8'h57, 5'h00);
        add_case(8'h5f, 8'h80, 8'h80, 1'b0, 8'h00, 5'h0d);
        add_case(8'h00, 8'h0f, 8'h01, 1'b0, 8'h10, 5'h02);
        add_case(8'h01, 8'h7f, 8'h01, 1'b0, 8'h80, 5'h1a);
        xfer(1'b1, 8'h10, 32'h1f);
        for (int b = 0; b < 8; b++) begin
            put(12'ha0a, 8'h55);
            xfer(1'b1, 8'h14, {16'h0, 4'h8, b[2:0], 1'b0, 8'h0a});
            rd(8'h1c, 32'h55 | (32'h1 << b), "bit");
            rd(8'h10, 32'h1f, "flags");
        end
        rd(8'h04, 32'h80, "work kept");
        xfer(1'b1, 8'h0c, 32'h3);
        put(12'h310, 8'h05);
        xfer(1'b1, 8'h04, 32'h01);
        xfer(1'b1, 8'h14, 32'h2510);
        rd(8'h04, 32'h06, "work bank");
        rd(8'h20, 32'h310, "eaddr bank");
        xfer(1'b1, 8'h14, 32'h8060);
        rd(8'h20, 32'hf60, "eaddr high");
        xfer(1'b1, 8'h00, 32'h0);
        xfer(1'b1, 8'h14, 32'h8010);
        rd(8'h20, 32'h010, "eaddr legacy");
        xfer(1'b1, 8'h14, 32'h0000);
        rd(8'h00, 32'h2, "illegal flag");
        xfer(1'b1, 8'h00, 32'h2);
        rd(8'h00, 32'h0, "illegal clear");
        xfer(1'b0, 8'h24, 32'h0);
        chk("slverr", 32'h1, {31'h0, re});
        close_out();
    end

    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        close_out();
    end
endmodule // tb_top

`default_nettype wire
